// [verilog/shadow_ram_dev.sv]
// Device end: shadow RAM with nonvolatile copy and serial command port
`timescale 1ns/1ps
`include "shadow_ram_params.svh"

module shadow_ram_dev
    import shadow_ram_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    shadow_ram_if.dev link,
    input  wire logic save_n,
    input  wire logic restore_n,
    output logic      busy,
    output logic      write_enabled,
    output logic      sleeping
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_INSTR, ST_WDATA, ST_RDATA, ST_HOLD, ST_SAVE, ST_RESTORE
    } dev_state_t;

    // =========================================================
    // Storage
    word_t ram_r    [`SR_WORDS];
    word_t shadow_r [`SR_WORDS];

    // =========================================================
    // Input synchronisers
    logic sel_s, sck_s, din_s, save_s, rest_s;
    sync2 #(.RST_VAL(1'b0)) u_sel  (.mclk(mclk), .resetn(resetn), .d(link.select),
                                    .q(sel_s));
    sync2 #(.RST_VAL(1'b1)) u_sck  (.mclk(mclk), .resetn(resetn),
                                    .d(link.serial_shift_clock), .q(sck_s));
    sync2 #(.RST_VAL(1'b0)) u_din  (.mclk(mclk), .resetn(resetn),
                                    .d(link.serial_in_line), .q(din_s));
    sync2 #(.RST_VAL(1'b1)) u_save (.mclk(mclk), .resetn(resetn), .d(save_n),
                                    .q(save_s));
    sync2 #(.RST_VAL(1'b1)) u_rest (.mclk(mclk), .resetn(resetn), .d(restore_n),
                                    .q(rest_s));

    // =========================================================
    // State
    dev_state_t state_r, state_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [3:0]  addr_r, addr_nxt;
    logic        sck_d_r;
    // Host may move data with the rising clock: take the bit seen a cycle before
    logic        din_d_r;
    logic        wen_r, wen_nxt;
    logic        sleep_r, sleep_nxt;
    logic        dout_r, dout_nxt;
    logic        oe_r, oe_nxt;
    logic        save_d_r, rest_d_r;
    logic [23:0] timer_r, timer_nxt;
    logic        ram_we;
    logic        do_save, do_restore;

    localparam logic [23:0] SAVE_CYC = 24'(`SR_SAVE_CYCLES);

    wire rise = sck_s & ~sck_d_r;
    wire fall = ~sck_s & sck_d_r;
    wire save_pin_edge = ~save_s & save_d_r;
    wire rest_pin_edge = ~rest_s & rest_d_r;

    function automatic logic is_op(input logic [7:0] ins, input logic [2:0] tail);
        return ins[7] == `SR_OP_ADDR_MARK && ins[2:0] == tail;
    endfunction

    always_comb begin
        state_nxt  = state_r;
        shift_nxt  = shift_r;
        cnt_nxt    = cnt_r;
        addr_nxt   = addr_r;
        wen_nxt    = wen_r;
        sleep_nxt  = sleep_r;
        dout_nxt   = dout_r;
        oe_nxt     = oe_r;
        timer_nxt  = timer_r;
        ram_we     = 1'b0;
        do_save    = 1'b0;
        do_restore = 1'b0;
        unique case (state_r)
            ST_SAVE: begin
                // Shadow copy lands at the end so the hold time is honoured
                oe_nxt = 1'b0;
                if (timer_r == SAVE_CYC - 24'h1) begin
                    do_save   = 1'b1;
                    state_nxt = ST_IDLE;
                end else begin
                    timer_nxt = timer_r + 24'h1;
                end
            end
            ST_RESTORE: begin
                do_restore = 1'b1;
                state_nxt  = ST_IDLE;
            end
            default: begin
                if (save_pin_edge) begin
                    state_nxt = ST_SAVE;
                    timer_nxt = 24'h0;
                    oe_nxt    = 1'b0;
                end else if (rest_pin_edge) begin
                    state_nxt = ST_RESTORE;
                    oe_nxt    = 1'b0;
                end else if (!sel_s) begin
                    state_nxt = ST_IDLE;
                    oe_nxt    = 1'b0;
                    cnt_nxt   = 5'h0;
                end else begin
                    unique case (state_r)
                        ST_IDLE: begin
                            state_nxt = ST_INSTR;
                            cnt_nxt   = 5'h0;
                        end
                        ST_INSTR: begin
                            if (rise) begin
                                shift_nxt = {shift_r[14:0], din_d_r};
                                cnt_nxt   = cnt_r + 5'h1;
                                if (cnt_r == 5'h7) begin
                                    cnt_nxt   = 5'h0;
                                    sleep_nxt = 1'b0;
                                    addr_nxt  = shift_r[5:2];
                                    if (is_op({shift_r[6:0], din_d_r}, `SR_OP_RD_TAIL))
                                        state_nxt = ST_RDATA;
                                    else if (is_op({shift_r[6:0], din_d_r}, `SR_OP_WR_TAIL))
                                        state_nxt = ST_WDATA;
                                    else begin
                                        state_nxt = ST_HOLD;
                                        unique case ({shift_r[6:0], din_d_r})
                                            `SR_OP_WREN:    wen_nxt   = 1'b1;
                                            `SR_OP_WRDIS:   wen_nxt   = 1'b0;
                                            `SR_OP_SLEEP:   sleep_nxt = 1'b1;
                                            `SR_OP_SAVE: begin
                                                if (wen_r) begin
                                                    state_nxt = ST_SAVE;
                                                    timer_nxt = 24'h0;
                                                end
                                            end
                                            `SR_OP_RESTORE: state_nxt = ST_RESTORE;
                                            default: ;
                                        endcase
                                    end
                                end
                            end
                        end
                        ST_WDATA: begin
                            if (rise) begin
                                shift_nxt = {shift_r[14:0], din_d_r};
                                cnt_nxt   = cnt_r + 5'h1;
                                if (cnt_r == 5'hf) begin
                                    ram_we    = wen_r;
                                    state_nxt = ST_HOLD;
                                end
                            end
                        end
                        ST_RDATA: begin
                            // Change data on the falling edge so the host samples it stable
                            if (fall) begin
                                if (cnt_r == 5'h10) begin
                                    oe_nxt    = 1'b0;
                                    state_nxt = ST_HOLD;
                                end else begin
                                    oe_nxt   = 1'b1;
                                    dout_nxt = ram_r[addr_r][4'hf - 4'(cnt_r)];
                                    cnt_nxt  = cnt_r + 5'h1;
                                end
                            end
                        end
                        default: ;                              // ST_HOLD waits for deselect
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r  <= ST_IDLE;
            shift_r  <= 16'h0;
            cnt_r    <= 5'h0;
            addr_r   <= 4'h0;
            sck_d_r  <= 1'b1;
            din_d_r  <= 1'b0;
            wen_r    <= 1'b0;
            sleep_r  <= 1'b0;
            dout_r   <= 1'b0;
            oe_r     <= 1'b0;
            save_d_r <= 1'b1;
            rest_d_r <= 1'b1;
            timer_r  <= 24'h0;
        end else begin
            state_r  <= state_nxt;
            shift_r  <= shift_nxt;
            cnt_r    <= cnt_nxt;
            addr_r   <= addr_nxt;
            sck_d_r  <= sck_s;
            din_d_r  <= din_s;
            wen_r    <= wen_nxt;
            sleep_r  <= sleep_nxt;
            dout_r   <= dout_nxt;
            oe_r     <= oe_nxt;
            save_d_r <= save_s;
            rest_d_r <= rest_s;
            timer_r  <= timer_nxt;
        end
    end

    // Arrays carry no reset: contents survive like real cells
    always_ff @(posedge mclk) begin
        if (ram_we)
            ram_r[addr_r] <= {shift_r[14:0], din_d_r};
        for (int i = 0; i < `SR_WORDS; i++) begin
            if (do_save)
                shadow_r[i] <= ram_r[i];
            if (do_restore)
                ram_r[i] <= shadow_r[i];
        end
    end

    assign link.dout      = dout_r;
    assign link.dout_oe   = oe_r;
    assign busy           = (state_r == ST_SAVE) || (state_r == ST_RESTORE);
    assign write_enabled  = wen_r;
    assign sleeping       = sleep_r;
endmodule

// [verilog/shadow_ram_params.svh]
// Constants for the serial shadow RAM link and its two ends
`ifndef SHADOW_RAM_PARAMS_SVH
`define SHADOW_RAM_PARAMS_SVH

// =========================================================
// Geometry
`define SR_WORDS        16
`define SR_WORD_BITS    16
`define SR_ADDR_BITS    4
`define SR_INSTR_BITS   8

// =========================================================
// Instruction codes
`define SR_OP_WRDIS     8'hf8
`define SR_OP_SAVE      8'hf9
`define SR_OP_SLEEP     8'hfa
`define SR_OP_WREN      8'hfc
`define SR_OP_RESTORE   8'hfd
`define SR_OP_ADDR_MARK 1'b1
`define SR_OP_RD_TAIL   3'h6
`define SR_OP_WR_TAIL   3'h3

// =========================================================
// Timing
`define SR_CLK_HZ       40000000
`define SR_SAVE_MS      10
`define SR_SAVE_LIMIT   ((`SR_CLK_HZ / 1000) * `SR_SAVE_MS)
// Cell programming time; any nonzero value below the limit is legal
`define SR_SAVE_CYCLES  2000
// Round trip through both synchronisers needs more than 5 cycles per half
`define SR_DIV_HALF     8

`endif

// [verilog/shadow_ram_pkg.sv]
// Types shared by the shadow RAM device and host ends
package shadow_ram_pkg;
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_WREN,
        CMD_WRDIS,
        CMD_SAVE,
        CMD_RESTORE,
        CMD_SLEEP
    } host_cmd_t;

    typedef logic [15:0] word_t;
endpackage

// [verilog/shadow_ram_if.sv]
// Four-line serial link between host and shadow RAM device
`timescale 1ns/1ps
interface shadow_ram_if;
    logic select;
    logic serial_shift_clock;
    logic serial_in_line;
    logic dout;
    logic dout_oe;

    modport dev  (input select, input serial_shift_clock, input serial_in_line,
                  output dout, output dout_oe);
    modport host (output select, output serial_shift_clock, output serial_in_line,
                  input dout, input dout_oe);
endinterface

// [verilog/sync2.sv]
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// [verilog/shadow_ram_host.sv]
// Host end: bit-bangs instructions and words onto the serial link
`timescale 1ns/1ps
`include "shadow_ram_params.svh"
module shadow_ram_host
    import shadow_ram_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    shadow_ram_if.host link,
    input  wire logic cmd_valid,
    output logic      cmd_ready,
    input  host_cmd_t cmd,
    input  wire logic [3:0] cmd_addr,
    input  word_t     cmd_wdata,
    output word_t     rd_data,
    output logic      rd_valid
);
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_DONE} host_state_t;

    logic din_s;
    sync2 #(.RST_VAL(1'b0)) u_din (.mclk(mclk), .resetn(resetn), .d(link.dout),
                                   .q(din_s));

    host_state_t state_r, state_nxt;
    logic [23:0] out_r, out_nxt;
    logic [15:0] in_r, in_nxt;
    logic [5:0]  bits_r, bits_nxt;
    logic        rd_r, rd_nxt;
    logic [2:0]  div_r, div_nxt;
    logic        phase_r, phase_nxt;
    logic        sck_r, sck_nxt;
    logic        sel_r, sel_nxt;
    word_t       rdata_r, rdata_nxt;
    logic        rv_r, rv_nxt;

    function automatic logic [7:0] opcode(input host_cmd_t c, input logic [3:0] a);
        unique case (c)
            CMD_READ:  return {`SR_OP_ADDR_MARK, a, `SR_OP_RD_TAIL};
            CMD_WRITE: return {`SR_OP_ADDR_MARK, a, `SR_OP_WR_TAIL};
            CMD_WREN:  return `SR_OP_WREN;
            CMD_WRDIS: return `SR_OP_WRDIS;
            CMD_SAVE:  return `SR_OP_SAVE;
            CMD_RESTORE: return `SR_OP_RESTORE;
            default:   return `SR_OP_SLEEP;
        endcase
    endfunction

    wire tick = (div_r == 3'(`SR_DIV_HALF - 1));

    always_comb begin
        state_nxt = state_r;
        out_nxt   = out_r;
        in_nxt    = in_r;
        bits_nxt  = bits_r;
        rd_nxt    = rd_r;
        div_nxt   = tick ? 3'h0 : div_r + 3'h1;
        phase_nxt = phase_r;
        sck_nxt   = sck_r;
        sel_nxt   = sel_r;
        rdata_nxt = rdata_r;
        rv_nxt    = 1'b0;
        cmd_ready = 1'b0;
        unique case (state_r)
            H_IDLE: begin
                cmd_ready = 1'b1;
                if (cmd_valid) begin
                    out_nxt   = {opcode(cmd, cmd_addr), cmd_wdata};
                    bits_nxt  = (cmd == CMD_READ) ? 6'd24 :
                                (cmd == CMD_WRITE) ? 6'd24 : 6'd8;
                    rd_nxt    = (cmd == CMD_READ);
                    sel_nxt   = 1'b1;
                    div_nxt   = 3'h0;
                    phase_nxt = 1'b0;
                    state_nxt = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (tick) begin
                    if (!phase_r) begin
                        sck_nxt   = 1'b0;
                        phase_nxt = 1'b1;
                    end else begin
                        sck_nxt   = 1'b1;
                        phase_nxt = 1'b0;
                        if (rd_r && bits_r <= 6'd16)
                            in_nxt = {in_r[14:0], din_s};
                        out_nxt  = {out_r[22:0], 1'b0};
                        bits_nxt = bits_r - 6'h1;
                        if (bits_r == 6'h1)
                            state_nxt = H_DONE;
                    end
                end
            end
            default: begin
                sel_nxt   = 1'b0;
                rdata_nxt = in_r;
                rv_nxt    = rd_r;
                state_nxt = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_r <= H_IDLE;
            out_r   <= 24'h0;
            in_r    <= 16'h0;
            bits_r  <= 6'h0;
            rd_r    <= 1'b0;
            div_r   <= 3'h0;
            phase_r <= 1'b0;
            sck_r   <= 1'b1;
            sel_r   <= 1'b0;
            rdata_r <= 16'h0;
            rv_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            out_r   <= out_nxt;
            in_r    <= in_nxt;
            bits_r  <= bits_nxt;
            rd_r    <= rd_nxt;
            div_r   <= div_nxt;
            phase_r <= phase_nxt;
            sck_r   <= sck_nxt;
            sel_r   <= sel_nxt;
            rdata_r <= rdata_nxt;
            rv_r    <= rv_nxt;
        end
    end

    // Stop driving data during the read word so the shared wire is free
    assign link.serial_in_line     = (rd_r && bits_r <= 6'd16) ? 1'b0 : out_r[23];
    assign link.serial_shift_clock = sck_r;
    assign link.select             = sel_r;
    assign rd_data                 = rdata_r;
    assign rd_valid                = rv_r;
endmodule

// [tb/shadow_ram_properties.sv]
// Concurrent checks on the serial link between the two shadow RAM ends
`timescale 1ns/1ps
module shadow_ram_properties (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic select,
    input wire logic serial_shift_clock,
    input wire logic serial_in_line,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic save_n,
    input wire logic restore_n,
    input wire logic busy,
    input wire logic write_enabled,
    input wire logic sleeping
);
    // 10 ms at 40 MHz
    localparam int MAX_BUSY = 400000;

    int unsigned busy_cnt_r;
    int unsigned busy_cnt_nxt;

    // ==========================================
    // Length of the current busy stretch
    always_comb begin
        busy_cnt_nxt = busy ? busy_cnt_r + 1 : 0;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ==========================================
    // Properties
    property p_oe_drops_on_deselect;
        $fell(select) |-> ##[0:5] !dout_oe;
    endproperty
    a_oe_drops_on_deselect: assert property (p_oe_drops_on_deselect)
        else $error("data out still driven after deselect");

    property p_quiet_unselected;
        (!select) [*6] |-> !dout_oe;
    endproperty
    a_quiet_unselected: assert property (p_quiet_unselected)
        else $error("device drives data out while not selected");

    property p_dout_holds_after_rise;
        $rose(serial_shift_clock) && dout_oe |-> ##1 (!dout_oe || $stable(dout)) [*4];
    endproperty
    a_dout_holds_after_rise: assert property (p_dout_holds_after_rise)
        else $error("read bit changed while clock high");

    property p_shared_line_free;
        dout_oe |-> !serial_in_line;
    endproperty
    a_shared_line_free: assert property (p_shared_line_free)
        else $error("both ends drive the shared data line");

    property p_save_time;
        busy |-> busy_cnt_r <= MAX_BUSY;
    endproperty
    a_save_time: assert property (p_save_time)
        else $error("save runs longer than its limit");

    property p_pin_save_starts;
        $fell(save_n) && !busy |-> ##[1:6] busy;
    endproperty
    a_pin_save_starts: assert property (p_pin_save_starts)
        else $error("save pin did not start a save");

    property p_pin_restore_starts;
        $fell(restore_n) && !busy |-> ##[1:6] busy;
    endproperty
    a_pin_restore_starts: assert property (p_pin_restore_starts)
        else $error("restore pin did not start a restore");

    property p_busy_freezes_flags;
        busy ##1 busy |-> $stable(write_enabled) && $stable(sleeping);
    endproperty
    a_busy_freezes_flags: assert property (p_busy_freezes_flags)
        else $error("instruction taken while busy");

    property p_wren_needs_select;
        $rose(write_enabled) |-> select || $past(select, 1) || $past(select, 2)
            || $past(select, 3) || $past(select, 4) || $past(select, 5);
    endproperty
    a_wren_needs_select: assert property (p_wren_needs_select)
        else $error("write enable set without select");

    property p_clock_idles_high;
        !select && !$past(select) |-> serial_shift_clock;
    endproperty
    a_clock_idles_high: assert property (p_clock_idles_high)
        else $error("serial clock low outside a frame");

    c_read_drive: cover property ($rose(dout_oe));
    c_long_save: cover property (busy ##1 busy);
    c_sleep: cover property ($rose(sleeping));
    c_wren: cover property ($rose(write_enabled));
endmodule

// [tb/shadow_ram_tb_top.sv]
// Self-checking bench: host end drives device end, compared with a word model
`timescale 1ns/1ps
`include "shadow_ram_params.svh"
module shadow_ram_tb_top;
    import shadow_ram_pkg::*;

    // Planned run is near 60k cycles
    localparam int LIMIT = 90000;

    logic      mclk;
    logic      resetn;
    logic      save_n;
    logic      restore_n;
    logic      busy;
    logic      write_enabled;
    logic      sleeping;
    logic      cmd_valid;
    logic      cmd_ready;
    host_cmd_t cmd;
    logic [3:0] cmd_addr;
    word_t     cmd_wdata;
    word_t     rd_data;
    logic      rd_valid;
    int        fail_count;
    int        check_count;
    int        cyc;
    int        ram_m [16];
    int        shadow_m [16];

    shadow_ram_if link_if ();

    shadow_ram_dev shadow_ram_dev_inst (
        .mclk          (mclk),
        .resetn        (resetn),
        .link          (link_if),
        .save_n        (save_n),
        .restore_n     (restore_n),
        .busy          (busy),
        .write_enabled (write_enabled),
        .sleeping      (sleeping)
    );

    shadow_ram_host shadow_ram_host_inst (
        .mclk      (mclk),
        .resetn    (resetn),
        .link      (link_if),
        .cmd_valid (cmd_valid),
        .cmd_ready (cmd_ready),
        .cmd       (cmd),
        .cmd_addr  (cmd_addr),
        .cmd_wdata (cmd_wdata),
        .rd_data   (rd_data),
        .rd_valid  (rd_valid)
    );

    shadow_ram_properties shadow_ram_properties_inst (
        .mclk               (mclk),
        .resetn             (resetn),
        .select             (link_if.select),
        .serial_shift_clock (link_if.serial_shift_clock),
        .serial_in_line     (link_if.serial_in_line),
        .dout               (link_if.dout),
        .dout_oe            (link_if.dout_oe),
        .save_n             (save_n),
        .restore_n          (restore_n),
        .busy               (busy),
        .write_enabled      (write_enabled),
        .sleeping           (sleeping)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ==========================================
    // Cycle count and hang guard
    always @(posedge mclk) begin
        if (!resetn) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
    end

    // ==========================================
    // Shared tasks
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One host command, then wait until the link has been idle a while
    task automatic do_cmd(input host_cmd_t c, input logic [3:0] a, input word_t d,
                          output word_t rd);
        int k;
        @(negedge mclk);
        cmd       = c;
        cmd_addr  = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        // Ready is settled at the falling edge; the next rising edge takes the command
        while (cmd_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        rd = 16'h0000;
        k = 0;
        // Idle gap also keeps select low long enough between frames
        while (k < 8) begin
            @(posedge mclk);
            #1;
            if (rd_valid === 1'b1) rd = rd_data;
            k = (cmd_ready === 1'b1 && link_if.select === 1'b0) ? k + 1 : 0;
        end
    endtask

    task automatic read_all();
        word_t got;
        for (int i = 0; i < 16; i++) begin
            do_cmd(CMD_READ, i[3:0], 16'h0000, got);
            check("read_word", got, ram_m[i][15:0]);
        end
    endtask

    task automatic write_all();
        word_t dummy;
        for (int i = 0; i < 16; i++) begin
            ram_m[i] = $urandom & 32'hffff;
            do_cmd(CMD_WRITE, i[3:0], ram_m[i][15:0], dummy);
        end
    endtask

    task automatic wait_busy(input int lim, output int took);
        int c0;
        c0 = cyc;
        while (busy !== 1'b0 && cyc - c0 < lim) @(posedge mclk);
        took = cyc - c0;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        word_t dummy;
        int    took;
        fail_count = 0;
        check_count = 0;
        resetn = 1'b0;
        save_n = 1'b1;
        restore_n = 1'b1;
        cmd_valid = 1'b0;
        cmd = CMD_READ;
        cmd_addr = 4'h0;
        cmd_wdata = 16'h0000;
        void'($urandom(32'h7812));
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        fork
            begin
                do_cmd(CMD_WREN, 4'h0, 16'h0000, dummy);
                check("wren_flag", write_enabled, 1'b1);
                write_all();
                read_all();
                $display("test write_read done");

                do_cmd(CMD_WRDIS, 4'h0, 16'h0000, dummy);
                check("wrdis_flag", write_enabled, 1'b0);
                do_cmd(CMD_WRITE, 4'h3, ~ram_m[3][15:0], dummy);
                do_cmd(CMD_SAVE, 4'h0, 16'h0000, dummy);
                check("save_refused", busy, 1'b0);
                read_all();
                $display("test write_protect done");

                do_cmd(CMD_SLEEP, 4'h0, 16'h0000, dummy);
                check("sleep_flag", sleeping, 1'b1);
                do_cmd(CMD_WREN, 4'h0, 16'h0000, dummy);
                check("wake_flag", sleeping, 1'b0);
                $display("test sleep done");

                shadow_m = ram_m;
                @(negedge mclk);
                save_n = 1'b0;
                repeat (6) @(negedge mclk);
                check("pin_save_busy", busy, 1'b1);
                save_n = 1'b1;
                do_cmd(CMD_WRITE, 4'h5, ~ram_m[5][15:0], dummy);
                wait_busy(`SR_SAVE_CYCLES + 100, took);
                check("save_in_time", took <= `SR_SAVE_LIMIT && busy === 1'b0, 1'b1);
                read_all();
                $display("test pin_save done");

                write_all();
                read_all();
                @(negedge mclk);
                restore_n = 1'b0;
                repeat (6) @(negedge mclk);
                restore_n = 1'b1;
                wait_busy(100, took);
                ram_m = shadow_m;
                read_all();
                $display("test pin_restore done");

                write_all();
                do_cmd(CMD_RESTORE, 4'h0, 16'h0000, dummy);
                ram_m = shadow_m;
                read_all();
                $display("test serial_restore done");
            end
            begin
                // A stuck handshake ends the run here as a mismatch; wait_busy gives up on a stuck busy flag by itself
                wait (cyc >= LIMIT);
                fail_count++;
                $display("timeout after %0d cycles", cyc);
            end
        join_any
        final_report();
    end
endmodule
